// *** sim/dma_mac_asserts.sv ***
// Purpose: Port-level properties of the multiply/accumulate datapath.
// Assumes: One clock; asynchronous active-low reset.
// Notes: Bound onto the top module below the checker.
`default_nettype none

module dma_mac_asserts (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Command and control
	input wire logic cmd_valid,
	input wire dma_pkg::dma_cmd_s cmd,
	input wire logic [dma_pkg::CFG_W-1:0] core_config_reg,
	input wire logic clip_clear_a,
	input wire logic clip_clear_b,
	// Results
	input wire logic [dma_pkg::ACC_W-1:0] acc_a,
	input wire logic [dma_pkg::ACC_W-1:0] acc_b,
	input wire logic acc_done,
	input wire logic [dma_pkg::RAW_W-1:0] core_product,
	input wire logic core_product_valid,
	input wire dma_pkg::dma_flags_s flags
);
	// ************************************************************
	// Helpers
	// ************************************************************
	logic core_op;
	logic acc_op;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	assign core_op = cmd_valid && cmd.op == dma_pkg::core_product_op;
	assign acc_op = cmd_valid && cmd.op != dma_pkg::idle_op && !core_op;
	sequence a_raw_s;
		acc_op && !cmd.acc_sel && !core_config_reg[dma_pkg::CFG_CLIP_A_BIT];
	endsequence
	sequence a_clip32_s;
		acc_op && !cmd.acc_sel && core_config_reg[dma_pkg::CFG_CLIP_A_BIT]
			&& !core_config_reg[dma_pkg::CFG_CLIP_WIDTH_BIT];
	endsequence
	// ************************************************************
	// Properties
	// ************************************************************
	done_pulse_a: assert property (acc_op |=> acc_done)
		else $error("accumulator command gave no done pulse");
	done_quiet_a: assert property (!acc_op |=> !acc_done)
		else $error("done pulse without a command");
	core_valid_a: assert property (core_op |=> core_product_valid)
		else $error("core product valid missing");
	byte_upper_a: assert property (core_op && cmd.byte_mode |=> core_product[31:16] == 16'h0000)
		else $error("byte product upper half not zero");
	idle_hold_a: assert property (!acc_op |=> $stable(acc_a) && $stable(acc_b))
		else $error("accumulator changed without a command");
	other_hold_a: assert property (acc_op && !cmd.acc_sel |=> $stable(acc_b))
		else $error("accumulator B changed by an A command");
	guard_raw_a: assert property (a_raw_s |=> flags.acc_a_guard_overflow ==
		!((&acc_a[39:32]) || !(|acc_a[39:32])))
		else $error("guard flag of A disagrees with guard bits");
	guard_off32_a: assert property (a_clip32_s |=> !flags.acc_a_guard_overflow)
		else $error("guard flag set in 32-bit clip mode");
	either_guard_a: assert property (flags.either_guard_overflow ==
		(flags.acc_a_guard_overflow | flags.acc_b_guard_overflow))
		else $error("combined guard bit wrong");
	either_clip_a: assert property (flags.either_clip_flag ==
		(flags.acc_a_clip_flag | flags.acc_b_clip_flag))
		else $error("combined clip bit wrong");
	clip_hold_a: assert property ($fell(flags.acc_a_clip_flag) |-> $past(clip_clear_a))
		else $error("clip flag A cleared without request");
	clip_hold_b: assert property ($fell(flags.acc_b_clip_flag) |-> $past(clip_clear_b))
		else $error("clip flag B cleared without request");
endmodule : dma_mac_asserts

bind dma_multiplier_accumulator dma_mac_asserts u_dma_mac_asserts (
	.clk(clk), .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd(cmd),
	.core_config_reg(core_config_reg), .clip_clear_a(clip_clear_a),
	.clip_clear_b(clip_clear_b), .acc_a(acc_a), .acc_b(acc_b), .acc_done(acc_done),
	.core_product(core_product), .core_product_valid(core_product_valid), .flags(flags)
);

`default_nettype wire

// *** sim/tb.sv ***
// Purpose: Self-checking bench for the multiply/accumulate datapath.
// Assumes: Inputs change on the falling edge; results land one clock later.
// Notes: Expected values are worked out by hand from the arithmetic.
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk;
	logic arst_n;
	logic cmd_valid;
	dma_pkg::dma_cmd_s cmd;
	logic [dma_pkg::CFG_W-1:0] core_config_reg;
	logic clip_clear_a;
	logic clip_clear_b;
	logic [dma_pkg::ACC_W-1:0] acc_a;
	logic [dma_pkg::ACC_W-1:0] acc_b;
	logic acc_done;
	logic [dma_pkg::RAW_W-1:0] core_product;
	logic core_product_valid;
	dma_pkg::dma_flags_s flags;
	int miscompares;
	int checks_done;

	dma_multiplier_accumulator u_dma_multiplier_accumulator (
		.clk(clk), .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd(cmd),
		.core_config_reg(core_config_reg), .clip_clear_a(clip_clear_a),
		.clip_clear_b(clip_clear_b), .acc_a(acc_a), .acc_b(acc_b), .acc_done(acc_done),
		.core_product(core_product), .core_product_valid(core_product_valid), .flags(flags)
	);

	// ************************************************************
	// Tasks
	// ************************************************************
	task automatic check(input string what, input logic [39:0] exp, input logic [39:0] got);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// Called at a falling edge; holds the command over one rising edge
	task automatic send(input dma_pkg::dma_op_e op, input logic sel, input logic [2:0] mode,
			input logic [15:0] x, input logic [15:0] y, input logic [39:0] data);
		cmd_valid = 1'b1;
		cmd = '{op: op, acc_sel: sel, byte_mode: mode[2], x_unsigned: mode[1],
			y_unsigned: mode[0], x: x, y: y, data: data};
		@(negedge clk);
		if (op == dma_pkg::core_product_op) check("valid", 40'h1, {39'h0, core_product_valid});
		else check("done", 40'h1, {39'h0, acc_done});
	endtask : send

	task automatic mul(input dma_pkg::dma_op_e op, input logic sel, input logic [15:0] x,
			input logic [15:0] y);
		send(op, sel, 3'h0, x, y, 40'h0);
	endtask : mul

	task automatic dat(input dma_pkg::dma_op_e op, input logic sel, input logic [39:0] d);
		send(op, sel, 3'h0, 16'h0000, 16'h0000, d);
	endtask : dat

	task automatic results();
		$display("Comparisons %0d, mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : results

	// ************************************************************
	// Clock, watchdog and tests
	// ************************************************************
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	initial begin
		#(2000 * 8);
		miscompares++;
		results();
	end

	initial begin
		miscompares = 0;
		checks_done = 0;
		arst_n = 1'b0;
		cmd_valid = 1'b0;
		cmd = '0;
		core_config_reg = 16'h0001;
		clip_clear_a = 1'b0;
		clip_clear_b = 1'b0;
		repeat (10) @(negedge clk);
		arst_n = 1'b1;
		check("reset acc", 40'h0, acc_a | acc_b);
		check("reset flags", 40'h0, {34'h0, flags});
		dat(dma_pkg::load_accumulator_op, 1'b0, 40'h0);
		mul(dma_pkg::multiply_accumulate_op, 1'b0, 16'h0003, 16'hfffe);
		check("acc_a", 40'hff_ffff_fffa, acc_a);
		core_config_reg = 16'h1001;
		mul(dma_pkg::multiply_accumulate_op, 1'b0, 16'hffff, 16'h0001);
		check("acc_a", 40'hff_ffff_fff9, acc_a);
		mul(dma_pkg::core_product_op, 1'b0, 16'hffff, 16'h0002);
		check("core", 40'h00_0001_fffe, {8'h00, core_product});
		core_config_reg = 16'h0000;
		mul(dma_pkg::core_product_op, 1'b0, 16'hffff, 16'h0002);
		check("core", 40'h00_ffff_fffe, {8'h00, core_product});
		send(dma_pkg::core_product_op, 1'b0, 3'h7, 16'h00ff, 16'h00ff, 40'h0);
		check("core byte", 40'h00_0000_fe01, {8'h00, core_product});
		mul(dma_pkg::plain_product_op, 1'b1, 16'h4000, 16'h4000);
		check("acc_b", 40'h00_2000_0000, acc_b);
		mul(dma_pkg::plain_product_op, 1'b1, 16'h8000, 16'h8000);
		check("acc_b", 40'h00_7fff_ffff, acc_b);
		mul(dma_pkg::multiply_accumulate_op, 1'b1, 16'h8000, 16'h8000);
		check("acc_b", 40'h00_ffff_fffe, acc_b);
		mul(dma_pkg::plain_product_op, 1'b1, 16'h8000, 16'h4000);
		check("acc_b", 40'hff_c000_0000, acc_b);
		core_config_reg = 16'h0001;
		dat(dma_pkg::load_accumulator_op, 1'b0, 40'h0a);
		mul(dma_pkg::multiply_subtract_op, 1'b0, 16'h0002, 16'h0003);
		check("acc_a", 40'h04, acc_a);
		mul(dma_pkg::negated_product_op, 1'b0, 16'h0002, 16'h0003);
		check("acc_a", 40'hff_ffff_fffa, acc_a);
		mul(dma_pkg::euclid_distance_op, 1'b1, 16'h0005, 16'h0005);
		mul(dma_pkg::euclid_distance_acc_op, 1'b1, 16'h0003, 16'h0003);
		check("acc_b", 40'h22, acc_b);
		dat(dma_pkg::acc_add_op, 1'b0, 40'h0);
		check("acc_a", 40'h1c, acc_a);
		dat(dma_pkg::acc_sub_op, 1'b0, 40'h0);
		check("acc_a", 40'hff_ffff_fffa, acc_a);
		dat(dma_pkg::acc_negate_op, 1'b0, 40'h0);
		dat(dma_pkg::add_data_op, 1'b0, 40'h10);
		check("acc_a", 40'h16, acc_a);
		dat(dma_pkg::load_accumulator_op, 1'b0, 40'h00_ffff_ffff);
		dat(dma_pkg::add_data_op, 1'b0, 40'h1);
		check("acc_a", 40'h01_0000_0000, acc_a);
		check("flags", 40'h11, {34'h0, flags});
		dat(dma_pkg::add_data_op, 1'b1, 40'h01_0000_0000);
		check("flags", 40'h13, {34'h0, flags});
		dat(dma_pkg::load_accumulator_op, 1'b0, 40'h7f_ffff_ffff);
		dat(dma_pkg::add_data_op, 1'b0, 40'h1);
		check("acc_a", 40'h80_0000_0000, acc_a);
		check("flags", 40'h37, {34'h0, flags});
		dat(dma_pkg::load_accumulator_op, 1'b0, 40'h0);
		check("flags", 40'h36, {34'h0, flags});
		cmd_valid = 1'b0;
		clip_clear_a = 1'b1;
		clip_clear_b = 1'b1;
		@(negedge clk);
		clip_clear_a = 1'b0;
		clip_clear_b = 1'b0;
		check("flags", 40'h12, {34'h0, flags});
		core_config_reg = 16'h0091;
		dat(dma_pkg::load_accumulator_op, 1'b0, 40'h7f_ffff_ffff);
		dat(dma_pkg::add_data_op, 1'b0, 40'h1);
		check("acc_a", dma_pkg::SAT40_POS, acc_a);
		dat(dma_pkg::load_accumulator_op, 1'b0, 40'h80_0000_0000);
		dat(dma_pkg::add_data_op, 1'b0, 40'hff_ffff_ffff);
		check("acc_a", dma_pkg::SAT40_NEG, acc_a);
		core_config_reg = 16'h0081;
		dat(dma_pkg::load_accumulator_op, 1'b0, 40'h00_7fff_ffff);
		dat(dma_pkg::add_data_op, 1'b0, 40'h1);
		check("acc_a", dma_pkg::SAT32_POS, acc_a);
		check("flags", 40'h36, {34'h0, flags});
		dat(dma_pkg::load_accumulator_op, 1'b0, 40'hff_8000_0000);
		dat(dma_pkg::add_data_op, 1'b0, 40'hff_ffff_ffff);
		check("acc_a", dma_pkg::SAT32_NEG, acc_a);
		core_config_reg = 16'h0051;
		dat(dma_pkg::load_accumulator_op, 1'b1, 40'h7f_ffff_ffff);
		clip_clear_b = 1'b1;
		dat(dma_pkg::add_data_op, 1'b1, 40'h1);
		clip_clear_b = 1'b0;
		check("acc_b", dma_pkg::SAT40_POS, acc_b);
		check("flags", 40'h3e, {34'h0, flags});
		cmd_valid = 1'b0;
		repeat (2) @(negedge clk);
		results();
	end
endmodule : tb

`default_nettype wire

// *** src/dma_multiplier.sv ***
// Purpose: 17x17 multiplier with fractional scaler.
// Assumes: Combinational; the caller registers the outputs.
// Notes: raw_product is taken ahead of the scaler.
`default_nettype none

module dma_multiplier (
	// Operands
	input wire logic [dma_pkg::OPD_W-1:0] x,
	input wire logic [dma_pkg::OPD_W-1:0] y,
	input wire logic x_unsigned,
	input wire logic y_unsigned,
	input wire logic frac_mode,
	// Products
	output logic [dma_pkg::RAW_W-1:0] raw_product,
	output logic [dma_pkg::ACC_W-1:0] scaled_product
);

	logic signed [dma_pkg::MUL_IN_W-1:0] x_ext;
	logic signed [dma_pkg::MUL_IN_W-1:0] y_ext;
	logic signed [dma_pkg::FULL_PROD_W-1:0] full;
	logic [dma_pkg::PROD_W-1:0] scaled33;
	logic both_minus_one;

	// ************************************************************
	// Multiply and scale
	// ************************************************************
	always_comb begin
		x_ext = {(x_unsigned ? 1'b0 : x[dma_pkg::OPD_MSB]), x}; // [RQ1]
		y_ext = {(y_unsigned ? 1'b0 : y[dma_pkg::OPD_MSB]), y}; // [RQ1]
		full = x_ext * y_ext;
		raw_product = full[dma_pkg::RAW_W-1:0]; // [RQ8]
		both_minus_one = (x == dma_pkg::FRAC_MINUS_ONE) && (y == dma_pkg::FRAC_MINUS_ONE)
			&& !x_unsigned && !y_unsigned;
		if (frac_mode && both_minus_one) begin
			scaled33 = dma_pkg::FRAC_CORRECTED; // [RQ4]
		end else if (frac_mode) begin
			scaled33 = {full[dma_pkg::RAW_W-1:0], 1'b0}; // [RQ3]
		end else begin
			scaled33 = full[dma_pkg::PROD_W-1:0];
		end
		scaled_product = {{(dma_pkg::ACC_W-dma_pkg::PROD_W){scaled33[dma_pkg::PROD_MSB]}},
			scaled33}; // [RQ2]
	end

endmodule : dma_multiplier

`default_nettype wire

// *** src/dma_multiplier_accumulator.sv ***
// Purpose: Multiplier, 40-bit adder/subtracter, two accumulators, overflow and clip flags.
// Assumes: Decode presents at most one command per cycle; barrel shifting done upstream.
// Notes: Every result appears one clock after the command is taken.
//
// Behaviour
// RQ1 - Multiplier inputs widen to 17 bits, zero for unsigned, sign for signed.
// RQ2 - The 33-bit multiplier/scaler product is sign-extended to 40 bits.
// RQ3 - Fractional products shift left one place to give 1.31 alignment.
// RQ4 - Minus one times minus one fractional becomes the largest positive 1.31.
// RQ5 - Config bit 0 picks fractional or integer; bit 12 picks signed or unsigned.
// RQ6 - Accumulating, product, negated product and distance operations are always signed.
// RQ7 - The adder can negate one input without touching the stored operands.
// RQ8 - Core products come before the scaler, integer only; mode bit affects accumulate class.
// RQ9 - Core product gives 16 bits for bytes and 32 bits for words.
// RQ10 - Adder sign-extends inputs; A or B is both source and destination.
// RQ11 - Accumulator add and load take data already scaled by the shifter.
// RQ12 - One adder side can be zero; subtract complements with active-low borrow-in.
// RQ13 - Overflow out of bit 39 is catastrophic and latches into the clip flag.
// RQ14 - Guard overflow flags when bits 32 to 39 are not all equal.
// RQ15 - Saturation uses adder result, overflow, per-accumulator enables and width select.
// RQ16 - Guard and clip flags are latched separately for each accumulator.
// RQ17 - Combined bits give the OR of both guard flags and both clip flags.
// RQ18 - Clip flags update on each adder operation and hold until cleared.
// RQ19 - 40-bit saturation loads the most positive or most negative 9.31 value.
// RQ20 - 32-bit saturation clamps to 1.31 limits and never sets guard flags.
`default_nettype none

module dma_multiplier_accumulator (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Command from instruction decode
	input wire logic cmd_valid,
	input wire dma_pkg::dma_cmd_s cmd,
	// Configuration and flag clears
	input wire logic [dma_pkg::CFG_W-1:0] core_config_reg,
	input wire logic clip_clear_a,
	input wire logic clip_clear_b,
	// Accumulators
	output logic [dma_pkg::ACC_W-1:0] acc_a,
	output logic [dma_pkg::ACC_W-1:0] acc_b,
	output logic acc_done,
	// Core multiply result
	output logic [dma_pkg::RAW_W-1:0] core_product,
	output logic core_product_valid,
	// Status
	output dma_pkg::dma_flags_s flags
);

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic bits_differ(input logic [dma_pkg::ACC_W-1:0] v,
		input logic from_q31);
		logic [dma_pkg::ACC_MSB-dma_pkg::Q31_SIGN:0] top;
		logic [dma_pkg::ACC_MSB-dma_pkg::GUARD_LO:0] guard;
		top = v[dma_pkg::ACC_MSB:dma_pkg::Q31_SIGN];
		guard = v[dma_pkg::ACC_MSB:dma_pkg::GUARD_LO];
		if (from_q31) begin
			bits_differ = !((&top) || !(|top));
		end else begin
			bits_differ = !((&guard) || !(|guard));
		end
	endfunction : bits_differ

	function automatic logic [dma_pkg::OPD_W-1:0] widen_byte(
		input logic [dma_pkg::OPD_W-1:0] v, input logic uns);
		widen_byte = {{(dma_pkg::OPD_W-dma_pkg::BYTE_W){(uns ? 1'b0 : v[dma_pkg::BYTE_MSB])}},
			v[dma_pkg::BYTE_W-1:0]};
	endfunction : widen_byte

	// ************************************************************
	// Declarations
	// ************************************************************
	logic [dma_pkg::ACC_W-1:0] acc_r [dma_pkg::NUM_ACC];
	logic [dma_pkg::ACC_W-1:0] acc_nxt [dma_pkg::NUM_ACC];
	logic [dma_pkg::NUM_ACC-1:0] guard_r;
	logic [dma_pkg::NUM_ACC-1:0] guard_nxt;
	logic [dma_pkg::NUM_ACC-1:0] clip_r;
	logic [dma_pkg::NUM_ACC-1:0] clip_nxt;
	logic [dma_pkg::NUM_ACC-1:0] clip_clear;
	logic [dma_pkg::NUM_ACC-1:0] clip_enable;
	logic acc_done_r;
	logic acc_done_nxt;
	logic [dma_pkg::RAW_W-1:0] core_r;
	logic [dma_pkg::RAW_W-1:0] core_nxt;
	logic core_valid_r;
	logic core_valid_nxt;

	logic mac_class;
	logic is_core;
	logic acc_write;
	logic zero_a;
	logic subtract;
	logic int_mode;
	logic unsigned_sel;
	logic clip_width_sel;
	logic mul_x_uns;
	logic mul_y_uns;
	logic [dma_pkg::OPD_W-1:0] mul_x;
	logic [dma_pkg::OPD_W-1:0] mul_y;
	logic [dma_pkg::RAW_W-1:0] raw_product;
	logic [dma_pkg::ACC_W-1:0] scaled_product;
	logic [dma_pkg::ACC_W-1:0] add_a;
	logic [dma_pkg::ACC_W-1:0] add_b;
	logic [dma_pkg::ACC_W-1:0] add_b_true;
	logic [dma_pkg::ACC_W:0] sum_wide;
	logic [dma_pkg::ACC_W-1:0] sum;
	logic ovf39;
	logic ovf31;
	logic guard_ovf;
	logic true_negative;

	// ************************************************************
	// Configuration fields
	// ************************************************************
	assign int_mode = core_config_reg[dma_pkg::CFG_INT_MODE_BIT]; // [RQ5]
	assign unsigned_sel = core_config_reg[dma_pkg::CFG_UNSIGNED_BIT]; // [RQ5]
	assign clip_width_sel = core_config_reg[dma_pkg::CFG_CLIP_WIDTH_BIT];
	assign clip_enable = {core_config_reg[dma_pkg::CFG_CLIP_B_BIT],
		core_config_reg[dma_pkg::CFG_CLIP_A_BIT]}; // [RQ15]
	assign clip_clear = {clip_clear_b, clip_clear_a};

	// ************************************************************
	// Operation decode and operand select
	// ************************************************************
	always_comb begin
		mac_class = 1'b0;
		zero_a = 1'b0;
		subtract = 1'b0;
		is_core = 1'b0;
		case (cmd.op)
			dma_pkg::multiply_accumulate_op: begin
				mac_class = 1'b1;
			end
			dma_pkg::multiply_subtract_op: begin
				mac_class = 1'b1;
				subtract = 1'b1; // [RQ7]
			end
			dma_pkg::plain_product_op: begin
				mac_class = 1'b1;
				zero_a = 1'b1;
			end
			dma_pkg::negated_product_op: begin
				mac_class = 1'b1;
				zero_a = 1'b1;
				subtract = 1'b1; // [RQ7]
			end
			dma_pkg::euclid_distance_op: begin
				mac_class = 1'b1;
				zero_a = 1'b1;
			end
			dma_pkg::euclid_distance_acc_op: begin
				mac_class = 1'b1;
			end
			dma_pkg::load_accumulator_op: begin
				zero_a = 1'b1; // [RQ12]
			end
			dma_pkg::acc_sub_op: begin
				subtract = 1'b1;
			end
			dma_pkg::acc_negate_op: begin
				zero_a = 1'b1; // [RQ12]
				subtract = 1'b1;
			end
			dma_pkg::core_product_op: begin
				is_core = 1'b1;
			end
			default: begin
				mac_class = 1'b0;
			end
		endcase
		acc_write = cmd_valid && (cmd.op != dma_pkg::idle_op) && !is_core;

		// Accumulate class is always signed; distance squares x
		if (mac_class) begin
			mul_x_uns = 1'b0; // [RQ6]
			mul_y_uns = 1'b0; // [RQ6]
		end else begin
			mul_x_uns = cmd.x_unsigned | unsigned_sel; // [RQ5]
			mul_y_uns = cmd.y_unsigned | unsigned_sel; // [RQ5]
		end
		if (is_core && cmd.byte_mode) begin
			mul_x = widen_byte(cmd.x, mul_x_uns); // [RQ9]
			mul_y = widen_byte(cmd.y, mul_y_uns); // [RQ9]
		end else if ((cmd.op == dma_pkg::euclid_distance_op)
			|| (cmd.op == dma_pkg::euclid_distance_acc_op)) begin
			mul_x = cmd.x;
			mul_y = cmd.x;
		end else begin
			mul_x = cmd.x;
			mul_y = cmd.y;
		end
	end

	dma_multiplier u_mul (
		.x(mul_x),
		.y(mul_y),
		.x_unsigned(mul_x_uns),
		.y_unsigned(mul_y_uns),
		.frac_mode(mac_class && !int_mode), // [RQ8]
		.raw_product(raw_product),
		.scaled_product(scaled_product)
	);

	// ************************************************************
	// 40-bit adder/subtracter
	// ************************************************************
	always_comb begin
		add_a = zero_a ? '0 : acc_r[cmd.acc_sel]; // [RQ10] [RQ12]
		if (mac_class) begin
			add_b_true = scaled_product;
		end else if ((cmd.op == dma_pkg::load_accumulator_op)
			|| (cmd.op == dma_pkg::add_data_op)) begin
			add_b_true = cmd.data; // [RQ11]
		end else if (cmd.op == dma_pkg::acc_negate_op) begin
			add_b_true = acc_r[cmd.acc_sel];
		end else begin
			add_b_true = acc_r[!cmd.acc_sel];
		end
		add_b = subtract ? ~add_b_true : add_b_true; // [RQ7] [RQ12]
		// Borrow-in is active low: no borrow means a carry of one when subtracting
		sum_wide = {add_a[dma_pkg::ACC_MSB], add_a} + {add_b[dma_pkg::ACC_MSB], add_b}
			+ {{dma_pkg::ACC_W{1'b0}}, subtract}; // [RQ10] [RQ12]
		sum = sum_wide[dma_pkg::ACC_W-1:0];
		ovf39 = (add_a[dma_pkg::ACC_MSB] == add_b[dma_pkg::ACC_MSB])
			&& (sum[dma_pkg::ACC_MSB] != add_a[dma_pkg::ACC_MSB]); // [RQ13]
		ovf31 = bits_differ(sum, 1'b1);
		guard_ovf = bits_differ(sum, 1'b0); // [RQ14]
		true_negative = ovf39 ? !sum[dma_pkg::ACC_MSB] : sum[dma_pkg::ACC_MSB];
	end

	// ************************************************************
	// Per-accumulator saturation and flags
	// ************************************************************
	for (genvar i = 0; i < dma_pkg::NUM_ACC; i++) begin : g_acc
		logic upd;
		logic narrow_clip;
		logic clip_set;

		always_comb begin
			upd = acc_write && (cmd.acc_sel == i[0]); // [RQ10]
			narrow_clip = clip_enable[i] && !clip_width_sel;
			clip_set = ovf39 || (narrow_clip && ovf31); // [RQ13] [RQ15]
			acc_nxt[i] = acc_r[i];
			guard_nxt[i] = guard_r[i];
			if (upd) begin
				guard_nxt[i] = guard_ovf && !narrow_clip; // [RQ16] [RQ20]
				if (clip_enable[i] && clip_width_sel && ovf39) begin
					acc_nxt[i] = true_negative ? dma_pkg::SAT40_NEG
						: dma_pkg::SAT40_POS; // [RQ19]
				end else if (narrow_clip && (ovf39 || ovf31)) begin
					acc_nxt[i] = true_negative ? dma_pkg::SAT32_NEG
						: dma_pkg::SAT32_POS; // [RQ20]
				end else begin
					acc_nxt[i] = sum;
				end
			end
			// A new overflow wins over a clear in the same cycle
			clip_nxt[i] = (clip_r[i] && !clip_clear[i]) || (upd && clip_set); // [RQ18]
		end

		always_ff @(posedge clk or negedge arst_n) begin
			if (!arst_n) begin
				acc_r[i] <= dma_pkg::ACC_RESET;
				guard_r[i] <= 1'b0;
				clip_r[i] <= 1'b0;
			end else begin
				acc_r[i] <= acc_nxt[i];
				guard_r[i] <= guard_nxt[i];
				clip_r[i] <= clip_nxt[i];
			end
		end
	end

	// ************************************************************
	// Core product and completion
	// ************************************************************
	always_comb begin
		core_valid_nxt = cmd_valid && is_core;
		acc_done_nxt = acc_write;
		core_nxt = core_r;
		if (core_valid_nxt && cmd.byte_mode) begin
			core_nxt = {{(dma_pkg::RAW_W-dma_pkg::OPD_W){1'b0}},
				raw_product[dma_pkg::OPD_W-1:0]}; // [RQ9]
		end else if (core_valid_nxt) begin
			core_nxt = raw_product; // [RQ8] [RQ9]
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			core_r <= dma_pkg::CORE_RESET;
			core_valid_r <= 1'b0;
			acc_done_r <= 1'b0;
		end else begin
			core_r <= core_nxt;
			core_valid_r <= core_valid_nxt;
			acc_done_r <= acc_done_nxt;
		end
	end

	// ************************************************************
	// Status view
	// ************************************************************
	dma_pkg::dma_flags_s flags_r;
	dma_pkg::dma_flags_s flags_nxt;

	always_comb begin
		flags_nxt.acc_a_guard_overflow = guard_nxt[0]; // [RQ16]
		flags_nxt.acc_b_guard_overflow = guard_nxt[1]; // [RQ16]
		flags_nxt.acc_a_clip_flag = clip_nxt[0];
		flags_nxt.acc_b_clip_flag = clip_nxt[1];
		flags_nxt.either_guard_overflow = |guard_nxt; // [RQ17]
		flags_nxt.either_clip_flag = |clip_nxt; // [RQ17]
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			flags_r <= '0;
		end else begin
			flags_r <= flags_nxt;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign acc_a = acc_r[0];
	assign acc_b = acc_r[1];
	assign acc_done = acc_done_r;
	assign core_product = core_r;
	assign core_product_valid = core_valid_r;
	assign flags = flags_r;

endmodule : dma_multiplier_accumulator

`default_nettype wire

// *** src/dma_pkg.sv ***
// Purpose: Shared constants and types for the DSP multiply/accumulate datapath.
// Assumes: One core clock; decode supplies one command per cycle at most.
// Notes: Configuration bit positions follow the core configuration word.
`default_nettype none

package dma_pkg;

	// ************************************************************
	// Widths
	// ************************************************************
	localparam int OPD_W = 16;
	localparam int BYTE_W = 8;
	localparam int MUL_IN_W = 17;
	localparam int FULL_PROD_W = 34;
	localparam int PROD_W = 33;
	localparam int RAW_W = 32;
	localparam int ACC_W = 40;
	localparam int CFG_W = 16;
	localparam int NUM_ACC = 2;

	// ************************************************************
	// Bit positions
	// ************************************************************
	localparam int CFG_INT_MODE_BIT = 0;
	localparam int CFG_CLIP_WIDTH_BIT = 4;
	localparam int CFG_CLIP_B_BIT = 6;
	localparam int CFG_CLIP_A_BIT = 7;
	localparam int CFG_UNSIGNED_BIT = 12;
	localparam int ACC_MSB = 39;
	localparam int GUARD_LO = 32;
	localparam int Q31_SIGN = 31;
	localparam int PROD_MSB = 32;
	localparam int OPD_MSB = 15;
	localparam int BYTE_MSB = 7;

	// ************************************************************
	// Values
	// ************************************************************
	localparam logic [OPD_W-1:0] FRAC_MINUS_ONE = 16'h8000;
	localparam logic [PROD_W-1:0] FRAC_CORRECTED = 33'h0_7fff_ffff;
	localparam logic [ACC_W-1:0] SAT40_POS = 40'h7f_ffff_ffff;
	localparam logic [ACC_W-1:0] SAT40_NEG = 40'h80_0000_0000;
	localparam logic [ACC_W-1:0] SAT32_POS = 40'h00_7fff_ffff;
	localparam logic [ACC_W-1:0] SAT32_NEG = 40'hff_8000_0000;
	localparam logic [ACC_W-1:0] ACC_RESET = 40'h00_0000_0000;
	localparam logic [RAW_W-1:0] CORE_RESET = 32'h0000_0000;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [3:0] {
		idle_op = 4'h0,
		multiply_accumulate_op = 4'h1,
		multiply_subtract_op = 4'h2,
		plain_product_op = 4'h3,
		negated_product_op = 4'h4,
		euclid_distance_op = 4'h5,
		euclid_distance_acc_op = 4'h6,
		load_accumulator_op = 4'h7,
		add_data_op = 4'h8,
		acc_add_op = 4'h9,
		acc_sub_op = 4'ha,
		acc_negate_op = 4'hb,
		core_product_op = 4'hc
	} dma_op_e;

	typedef struct packed {
		dma_op_e op;
		logic acc_sel;
		logic byte_mode;
		logic x_unsigned;
		logic y_unsigned;
		logic [OPD_W-1:0] x;
		logic [OPD_W-1:0] y;
		logic [ACC_W-1:0] data;
	} dma_cmd_s;

	typedef struct packed {
		logic either_clip_flag;
		logic either_guard_overflow;
		logic acc_b_clip_flag;
		logic acc_a_clip_flag;
		logic acc_b_guard_overflow;
		logic acc_a_guard_overflow;
	} dma_flags_s;

endpackage : dma_pkg

`default_nettype wire
